// [core/dmacrs_params.svh]
// constants for the dma channel run/status block: offsets, fields, resets
// assumes a 32-bit plain register port with word addresses in bytes
`ifndef DMACRS_PARAMS_SVH
`define DMACRS_PARAMS_SVH

`define DMACRS_ADDR_W        8
`define DMACRS_OFS_CTRL_STAT 8'h00
`define DMACRS_OFS_CB_ADDR   8'h04
`define DMACRS_OFS_DEBUG     8'h08
`define DMACRS_OFS_IRQ_MASK  8'h0C

`define DMACRS_BIT_RUN       0
`define DMACRS_BIT_DONE      1
`define DMACRS_BIT_INT       2
`define DMACRS_BIT_REQ       3
`define DMACRS_BIT_RD_PAUSE  4
`define DMACRS_BIT_WR_PAUSE  5
`define DMACRS_BIT_REQ_STALL 6
`define DMACRS_BIT_DRAIN     7
`define DMACRS_BIT_ERROR     10
`define DMACRS_QOS_LO        16
`define DMACRS_QOS_HI        19
`define DMACRS_URG_LO        20
`define DMACRS_URG_HI        23
`define DMACRS_BIT_WDRAIN_EN 28
`define DMACRS_BIT_DBG_DIS   29

`define DMACRS_DBG_ERR_W     3
`define DMACRS_DBG_INT_ERR   8
`define DMACRS_DBG_INT_ERR_RST 1'b0

`define DMACRS_REQ_RESET     1'b1
`define DMACRS_QOS_RESET     4'h0
`define DMACRS_NREQ          32
`define DMACRS_SEL_W         5
`define DMACRS_WTALLY_W      8
`define DMACRS_BURST_BEATS   8'h04

`endif

// [core/dmacrs_pkg.sv]
// types for the dma channel run/status block
// assumes dmacrs_params.svh sits on the include path
`include "dmacrs_params.svh"
package dmacrs_pkg;
  typedef struct packed {
    logic [`DMACRS_ADDR_W-1:0] addr;
    logic [31:0]               wdata;
    logic                      wr;
    logic                      rd;
  } dmacrs_bus_t;

  typedef struct packed {
    logic [31:0]              next_block_pointer;
    logic [`DMACRS_SEL_W-1:0] sel;
    logic                     src_paced;
    logic                     dst_paced;
    logic                     int_en;
    logic [15:0]              beats;
  } dmacrs_cb_t;

  typedef enum logic [2:0] {
    DMACRS_IDLE,
    DMACRS_FETCH,
    DMACRS_MOVE,
    DMACRS_DRAIN,
    DMACRS_FINISH
  } dmacrs_state_t;
endpackage

// [core/dmacrs_req_sel.sv]
// picks the paced request and urgent line named by the peripheral select
// assumes request and urgent lines are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "dmacrs_params.svh"
module dmacrs_req_sel (
  input  wire logic [`DMACRS_NREQ-1:0]  req_lines,
  input  wire logic [`DMACRS_NREQ-1:0]  urg_lines,
  input  wire logic [`DMACRS_SEL_W-1:0] sel,
  output logic                          req_sel,
  output logic                          urg_sel
);
  logic [`DMACRS_NREQ-1:0] req_vec;
  logic [`DMACRS_NREQ-1:0] urg_vec;
  genvar g;
  generate
    for (g = 0; g < `DMACRS_NREQ; g++) begin : g_line
      // select zero is unpaced: always requesting, never urgent
      if (g == 0) begin : g_zero
        assign req_vec[g] = 1'b1;
        assign urg_vec[g] = 1'b0;
      end else begin : g_line_n
        assign req_vec[g] = req_lines[g];
        assign urg_vec[g] = urg_lines[g];
      end
    end
  endgenerate
  assign req_sel = req_vec[sel];
  assign urg_sel = urg_vec[sel];
endmodule
`default_nettype wire

// [core/dmacrs_top.sv]
// dma channel run/status: control register, chain sequencing, pause flags
// assumes a simple memory-side fetch port and a write-response tally input
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmacrs_params.svh"
module dmacrs_top (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire dmacrs_pkg::dmacrs_bus_t      bus,
  output logic [31:0]                       rdata_r,
  input  wire logic [`DMACRS_NREQ-1:0]      req_lines,
  input  wire logic [`DMACRS_NREQ-1:0]      urg_lines,
  input  wire logic                         dbg_hold,
  output logic                              cb_fetch_r,
  output logic [31:0]                       cb_fetch_addr_r,
  input  wire logic                         cb_valid,
  input  wire dmacrs_pkg::dmacrs_cb_t       cb_in,
  output logic                              rd_beat_r,
  output logic                              wr_beat_r,
  input  wire logic                         wr_resp,
  input  wire logic [`DMACRS_DBG_ERR_W-1:0] err_in,
  output logic [3:0]                        qos_r,
  output logic                              irq_r
);
  import dmacrs_pkg::*;

  dmacrs_state_t             state_r;
  dmacrs_cb_t                cb_r;
  logic                      run_r;
  logic                      done_r;
  logic                      int_r;
  logic                      req_flag_r;
  logic [3:0]                qos_val_r;
  logic [3:0]                urg_val_r;
  logic                      wdrain_en_r;
  logic                      dbg_dis_r;
  logic [31:0]               cb_addr_r;
  logic [`DMACRS_DBG_ERR_W-1:0] err_r;
  logic                      int_on_err_r;
  logic                      err_pend_r;
  logic [2:0]                mask_r;
  logic [15:0]               beats_r;
  logic [`DMACRS_WTALLY_W-1:0] wtally_r;
  logic                      req_sel;
  logic                      urg_sel;
  logic                      hold_eff;
  logic                      rd_pause;
  logic                      wr_pause;
  logic                      stall;
  logic                      move_ok;
  logic                      finish;
  logic                      wr_cs;
  logic                      rd_dbg;
  logic                      wr_dbg;
  logic [31:0]               cs_view;
  logic                      wr_issue;
  logic                      tally_inc;
  logic                      tally_dec;
  logic                      done_clr;
  logic                      int_clr;
  logic                      err_evt;
  logic                      done_nxt;
  logic                      int_nxt;

  // select zero maps to an always-requesting line, so unpaced moves never stall
  dmacrs_req_sel i_dmacrs_req_sel (
    .req_lines (req_lines),
    .urg_lines (urg_lines),
    .sel       (cb_r.sel),
    .req_sel   (req_sel),
    .urg_sel   (urg_sel)
  );

  assign wr_cs  = bus.wr && (bus.addr == `DMACRS_OFS_CTRL_STAT);
  assign wr_dbg = bus.wr && (bus.addr == `DMACRS_OFS_DEBUG);
  assign rd_dbg = bus.rd && (bus.addr == `DMACRS_OFS_DEBUG);

  // pause causes; hold is ignored when the debug-disable bit is set
  assign hold_eff = dbg_hold && !dbg_dis_r;
  assign stall    = (cb_r.src_paced || cb_r.dst_paced) && !req_sel;
  assign rd_pause = !run_r || hold_eff || (cb_r.src_paced && !req_sel);
  assign wr_pause = !run_r || hold_eff || (cb_r.dst_paced && !req_sel);
  // beats are atomic, so pausing between them is always a safe boundary
  assign move_ok  = (state_r == DMACRS_MOVE) && !rd_pause && !wr_pause
                    && (beats_r != 16'h0000);
  assign wr_issue = move_ok;
  assign tally_inc = wr_issue;
  assign tally_dec = wr_resp && (wtally_r != '0);
  // completion waits for the tally only when draining is enabled
  assign finish = ((state_r == DMACRS_MOVE) && (beats_r == 16'h0000) && !wdrain_en_r)
               || ((state_r == DMACRS_DRAIN) && (wtally_r == '0));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r         <= DMACRS_IDLE;
      cb_fetch_r      <= 1'b0;
      cb_fetch_addr_r <= 32'h0000_0000;
      beats_r         <= 16'h0000;
    end else begin
      cb_fetch_r <= 1'b0;
      unique case (state_r)
        DMACRS_IDLE: begin
          if (run_r && (cb_addr_r != 32'h0000_0000)) begin
            state_r         <= DMACRS_FETCH;
            cb_fetch_r      <= 1'b1;
            cb_fetch_addr_r <= cb_addr_r;
          end
        end
        DMACRS_FETCH: begin
          if (cb_valid) begin
            state_r <= DMACRS_MOVE;
            beats_r <= cb_in.beats;
          end
        end
        DMACRS_MOVE: begin
          if (move_ok) begin
            beats_r <= beats_r - 16'h0001;
          end else if (beats_r == 16'h0000) begin
            state_r <= wdrain_en_r ? DMACRS_DRAIN : DMACRS_FINISH;
          end
        end
        DMACRS_DRAIN: begin
          if (wtally_r == '0) begin
            state_r <= DMACRS_FINISH;
          end
        end
        DMACRS_FINISH: begin
          state_r <= DMACRS_IDLE;
        end
      endcase
    end
  end

  // control block capture; request mirror follows the selected request line every cycle in move and drain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cb_r <= '0;
    end else if ((state_r == DMACRS_FETCH) && cb_valid) begin
      cb_r <= cb_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_flag_r <= `DMACRS_REQ_RESET;
    end else if (state_r == DMACRS_MOVE || state_r == DMACRS_DRAIN) begin
      req_flag_r <= req_sel;
    end
  end

  // beat strobes are registered to keep every output on a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_beat_r <= 1'b0;
      wr_beat_r <= 1'b0;
    end else begin
      rd_beat_r <= move_ok;
      wr_beat_r <= wr_issue;
    end
  end

  // tally counts at issue, not at the registered beat, so drain sees the last write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wtally_r <= '0;
    end else if (tally_inc && !tally_dec) begin
      wtally_r <= wtally_r + `DMACRS_WTALLY_W'(1);
    end else if (!tally_inc && tally_dec) begin
      wtally_r <= wtally_r - `DMACRS_WTALLY_W'(1);
    end
  end

  // block address: software writes it, the chain reloads it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cb_addr_r <= 32'h0000_0000;
    end else if (state_r == DMACRS_FINISH) begin
      cb_addr_r <= cb_r.next_block_pointer;
    end else if (bus.wr && (bus.addr == `DMACRS_OFS_CB_ADDR)) begin
      cb_addr_r <= bus.wdata;
    end
  end

  // run bit: hardware auto-clear at chain end wins over a software write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (finish && (cb_r.next_block_pointer == 32'h0000_0000)) begin
      run_r <= 1'b0;
    end else if (wr_cs) begin
      run_r <= bus.wdata[`DMACRS_BIT_RUN];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qos_val_r   <= `DMACRS_QOS_RESET;
      urg_val_r   <= `DMACRS_QOS_RESET;
      wdrain_en_r <= 1'b0;
      dbg_dis_r   <= 1'b0;
    end else if (wr_cs) begin
      qos_val_r   <= bus.wdata[`DMACRS_QOS_HI:`DMACRS_QOS_LO];
      urg_val_r   <= bus.wdata[`DMACRS_URG_HI:`DMACRS_URG_LO];
      wdrain_en_r <= bus.wdata[`DMACRS_BIT_WDRAIN_EN];
      dbg_dis_r   <= bus.wdata[`DMACRS_BIT_DBG_DIS];
    end
  end

  // qos follows the urgent line one cycle late; a beat may go out at the old level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qos_r <= `DMACRS_QOS_RESET;
    end else begin
      qos_r <= urg_sel ? urg_val_r : qos_val_r;
    end
  end

  // error flags: new errors win over the read-side clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= '0;
    end else if (rd_dbg) begin
      err_r <= err_in;
    end else begin
      err_r <= err_r | err_in;
    end
  end

  // error interrupt enable sits in the debug register beside the flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_on_err_r <= `DMACRS_DBG_INT_ERR_RST;
    end else if (wr_dbg) begin
      int_on_err_r <= bus.wdata[`DMACRS_DBG_INT_ERR];
    end
  end

  // an error is only remembered here; it raises the flag at block end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_pend_r <= 1'b0;
    end else if (finish) begin
      err_pend_r <= 1'b0;
    end else if (err_evt) begin
      err_pend_r <= 1'b1;
    end
  end

  assign err_evt = int_on_err_r && (err_in != '0);

  // write-one clears first, then the set terms, so an event in the clear cycle survives
  always_comb begin
    done_clr = wr_cs && bus.wdata[`DMACRS_BIT_DONE];
    int_clr  = wr_cs && bus.wdata[`DMACRS_BIT_INT];
    done_nxt = done_r && !done_clr;
    int_nxt  = int_r && !int_clr;
    if (finish) begin
      done_nxt = 1'b1;
      if (cb_r.int_en || err_pend_r || err_evt) begin
        int_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      int_r  <= 1'b0;
    end else begin
      done_r <= done_nxt;
      int_r  <= int_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 3'h0;
    end else if (bus.wr && (bus.addr == `DMACRS_OFS_IRQ_MASK)) begin
      mask_r <= bus.wdata[2:0];
    end
  end

  // irq follows the next flag values: it rises with a flag and drops with its clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (int_nxt && mask_r[`DMACRS_BIT_INT])
               || (done_nxt && mask_r[`DMACRS_BIT_DONE]);
    end
  end

  always_comb begin
    cs_view = 32'h0000_0000;
    cs_view[`DMACRS_BIT_RUN]       = run_r;
    cs_view[`DMACRS_BIT_DONE]      = done_r;
    cs_view[`DMACRS_BIT_INT]       = int_r;
    cs_view[`DMACRS_BIT_REQ]       = req_flag_r;
    cs_view[`DMACRS_BIT_RD_PAUSE]  = rd_pause;
    cs_view[`DMACRS_BIT_WR_PAUSE]  = wr_pause;
    cs_view[`DMACRS_BIT_REQ_STALL] = stall && (state_r == DMACRS_MOVE);
    cs_view[`DMACRS_BIT_DRAIN]     = (state_r == DMACRS_DRAIN);
    cs_view[`DMACRS_BIT_ERROR]     = (err_r != '0);
    cs_view[`DMACRS_QOS_HI:`DMACRS_QOS_LO] = qos_val_r;
    cs_view[`DMACRS_URG_HI:`DMACRS_URG_LO] = urg_val_r;
    cs_view[`DMACRS_BIT_WDRAIN_EN] = wdrain_en_r;
    cs_view[`DMACRS_BIT_DBG_DIS]   = dbg_dis_r;
  end

  // unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `DMACRS_OFS_CTRL_STAT: rdata_r <= cs_view;
        `DMACRS_OFS_CB_ADDR:   rdata_r <= cb_addr_r;
        `DMACRS_OFS_DEBUG:     rdata_r <= {23'h0, int_on_err_r, 5'h00, err_r};
        `DMACRS_OFS_IRQ_MASK:  rdata_r <= {29'h0, mask_r};
        default:               rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [verification/dmacrs_mem_model.sv]
// partner: answers block fetches and returns write responses
// assumes one clock; chain length equals the starting block address
`timescale 1ns/1ps
`default_nettype none
module dmacrs_mem_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   slow,
  input  wire dmacrs_pkg::dmacrs_cb_t tpl,
  input  wire logic                   cb_fetch_r,
  input  wire logic [31:0]            cb_fetch_addr_r,
  input  wire logic                   wr_beat_r,
  output var  logic                   cb_valid,
  output var  dmacrs_pkg::dmacrs_cb_t cb_in,
  output var  logic                   wr_resp
);
  import dmacrs_pkg::*;
  logic [2:0] wait_r;
  logic [7:0] owed_r;
  logic       busy_r;
  logic       gap_r;
  // outside a valid cycle the block lines carry junk, not the last block
  always_comb begin
    cb_in = cb_valid ? tpl : ~tpl;
    cb_in.next_block_pointer = cb_fetch_addr_r - 32'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r   <= 1'b0;
      wait_r   <= 3'h0;
      cb_valid <= 1'b0;
    end else begin
      cb_valid <= 1'b0;
      if (cb_fetch_r) begin
        busy_r <= 1'b1;
        wait_r <= slow ? 3'h5 : 3'h0;
      end else if (busy_r && wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if (busy_r) begin
        busy_r   <= 1'b0;
        cb_valid <= 1'b1;
      end
    end
  end
  // slow mode answers every other cycle so writes pile up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      owed_r  <= 8'h0;
      gap_r   <= 1'b0;
      wr_resp <= 1'b0;
    end else begin
      owed_r  <= owed_r + 8'(wr_beat_r) - 8'(wr_resp);
      gap_r   <= slow ? ~gap_r : 1'b1;
      wr_resp <= (owed_r != 8'(wr_resp)) && gap_r;
    end
  end
endmodule
`default_nettype wire

// [verification/dmacrs_checker.sv]
// concurrent checks on the ports of dmacrs_top
// assumes single clock domain; bound to every dmacrs_top instance
`timescale 1ns/1ps
`default_nettype none
`include "dmacrs_params.svh"
module dmacrs_checker (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire dmacrs_pkg::dmacrs_bus_t  bus,
  input wire logic [`DMACRS_NREQ-1:0]  req_lines,
  input wire logic                     dbg_hold,
  input wire logic                     cb_fetch_r,
  input wire logic [31:0]              cb_fetch_addr_r,
  input wire logic                     cb_valid,
  input wire dmacrs_pkg::dmacrs_cb_t   cb_in,
  input wire logic                     rd_beat_r,
  input wire logic                     wr_beat_r,
  input wire logic                     wr_resp
);
  import dmacrs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic       pend_r, chain_r, nodbg_r, drain_r;
  logic [7:0] tally_r;
  dmacrs_cb_t blk_r;
  wire logic  ctl_wr = bus.wr && bus.addr == `DMACRS_OFS_CTRL_STAT;
  // chain_r: next fetch must come from the loaded pointer, not software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r  <= 1'b0;
      chain_r <= 1'b0;
      nodbg_r <= 1'b0;
      drain_r <= 1'b0;
      tally_r <= 8'h0;
      blk_r   <= '0;
    end else begin
      pend_r  <= cb_fetch_r || (pend_r && !cb_valid);
      if (pend_r && cb_valid) blk_r <= cb_in;
      chain_r <= (pend_r && cb_valid) || (chain_r && !(ctl_wr
                 || (bus.wr && bus.addr == `DMACRS_OFS_CB_ADDR)));
      if (ctl_wr) nodbg_r <= bus.wdata[`DMACRS_BIT_DBG_DIS];
      if (ctl_wr) drain_r <= bus.wdata[`DMACRS_BIT_WDRAIN_EN];
      tally_r <= tally_r + 8'(wr_beat_r) - 8'(wr_resp && tally_r != 8'h0);
    end
  end
  fetch_addr_a: assert property (
    cb_fetch_r |-> cb_fetch_addr_r != 32'h0) else $error("fetch at zero");
  fetch_pulse_a: assert property (
    cb_fetch_r |=> !cb_fetch_r) else $error("fetch pulse too long");
  load_wait_a: assert property (
    pend_r |-> !rd_beat_r && !wr_beat_r) else $error("beat before load");
  chain_next_a: assert property (
    cb_fetch_r && chain_r |-> blk_r.next_block_pointer != 32'h0
    && cb_fetch_addr_r == blk_r.next_block_pointer) else $error("bad chain");
  run_pause_a: assert property (
    ctl_wr && !bus.wdata[0] ##1 !bus.wr [*2] |=> !rd_beat_r && !wr_beat_r)
    else $error("beat after run off");
  hold_pause_a: assert property (
    (dbg_hold && !nodbg_r) [*3] |-> !rd_beat_r && !wr_beat_r)
    else $error("beat during hold");
  pace_stall_a: assert property (
    (blk_r.sel != 5'h0 && !req_lines[blk_r.sel]) [*2]
    |-> !(blk_r.src_paced && rd_beat_r) && !(blk_r.dst_paced && wr_beat_r))
    else $error("beat without request");
  drain_wait_a: assert property (
    cb_fetch_r && chain_r && drain_r |-> tally_r == 8'h0)
    else $error("moved on before drain");
endmodule
bind dmacrs_top dmacrs_checker i_dmacrs_checker (.clk_sys, .rst_n, .bus, .req_lines,
  .dbg_hold, .cb_fetch_r, .cb_fetch_addr_r, .cb_valid, .cb_in, .rd_beat_r, .wr_beat_r,
  .wr_resp);
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for dmacrs_top with the memory-side partner
// assumes package, params header, partner and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dmacrs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  dmacrs_bus_t bus;
  logic [31:0] rdata_r, fa, req_lines, urg_lines, f, v;
  logic        dbg_hold, cf, cv, rb, wb, wresp, irq, slow, seen7;
  logic [2:0]  err_in;
  logic [3:0]  qos, q, u;
  logic [4:0]  s;
  dmacrs_cb_t  cb_in, tpl;
  int          err_count, num_checks, cyc, nrd, nwr, nresp, nfetch, n;
  always #10 clk_sys = ~clk_sys;
  dmacrs_top i_dmacrs_top (.clk_sys, .rst_n, .bus, .rdata_r, .req_lines, .urg_lines,
    .dbg_hold, .cb_fetch_r(cf), .cb_fetch_addr_r(fa), .cb_valid(cv), .cb_in,
    .rd_beat_r(rb), .wr_beat_r(wb), .wr_resp(wresp), .err_in, .qos_r(qos), .irq_r(irq));
  dmacrs_mem_model i_dmacrs_mem_model (.clk_sys, .rst_n, .slow, .tpl, .cb_fetch_r(cf),
    .cb_fetch_addr_r(fa), .wr_beat_r(wb), .cb_valid(cv), .cb_in, .wr_resp(wresp));
  always @(posedge clk_sys) begin
    cyc++;
    nrd += rb;
    nwr += wb;
    nresp += wresp;
    nfetch += cf;
    if (cyc == 30000) begin
      err_count++;
      results;
    end
  end
  task automatic results;
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected beats over a chain of equally long blocks
  function automatic logic [31:0] chain_beats(input int nblk, input logic [15:0] b);
    return 32'(nblk) * {16'h0, b};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask
  // a zero mask reads without comparing
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
    v = rdata_r;
    if (m != 32'h0) chk("register", e, v & m);
  endtask
  task automatic start(input logic [31:0] a, input logic [31:0] c);
    nrd = 0;
    nwr = 0;
    nresp = 0;
    nfetch = 0;
    wr_reg(8'h04, a);
    wr_reg(8'h00, f | c);
  endtask
  task automatic wait_idle;
    v = 32'h1;
    for (int i = 0; i < 300 && v[0] === 1'b1; i++) begin
      rd_reg(8'h00, 32'h0, 32'h0);
      seen7 |= v[7];
    end
    chk("run", 32'h0, {31'h0, v[0]});
  endtask
  initial begin
    bus = '0;
    req_lines = '0;
    dbg_hold = 1'b0;
    err_in = 3'h0;
    slow = 1'b0;
    void'($urandom(16));
    q = 4'($urandom);
    u = 4'($urandom);
    s = 5'($urandom_range(31, 1));
    urg_lines = 32'h1 << s;
    f = {8'h0, u, q, 16'h0};
    tpl = '{32'h0, 5'h0, 1'b0, 1'b0, 1'b1, 16'($urandom_range(20, 1))};
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_reg(8'h00, 32'hFFFF_FFFF, 32'h38);
    rd_reg(8'h10, 32'hFFFF_FFFF, 32'h0);
    wr_reg(8'h00, f);
    rd_reg(8'h00, 32'h00FF_0000, f);
    chk("qos", {28'h0, q}, {28'h0, qos});
    wr_reg(8'h0C, 32'h6);
    rd_reg(8'h0C, 32'hFFFF_FFFF, 32'h6);
    start(32'h1, 32'h1);
    wait_idle;
    rd_reg(8'h00, 32'h7, 32'h6);
    chk("read beats", chain_beats(1, tpl.beats), nrd);
    chk("irq", 32'h1, {31'h0, irq});
    rd_reg(8'h04, 32'hFFFF_FFFF, 32'h0);
    wr_reg(8'h00, f);
    rd_reg(8'h00, 32'h6, 32'h6);
    wr_reg(8'h00, f | 32'h6);
    @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    slow <= 1'b1;
    seen7 = 1'b0;
    tpl.int_en <= 1'b0;
    tpl.beats <= 16'h10;
    start(32'h3, 32'h1000_0007);
    wait_idle;
    chk("fetches", 32'h3, nfetch);
    chk("write beats", chain_beats(3, tpl.beats), nwr);
    chk("responses", chain_beats(3, tpl.beats), nresp);
    chk("draining", 32'h1, {31'h0, seen7});
    rd_reg(8'h00, 32'h6, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    slow <= 1'b0;
    tpl.beats <= 16'h28;
    start(32'h1, 32'h7);
    repeat (4) @(posedge clk_sys);
    dbg_hold <= 1'b1;
    rd_reg(8'h00, 32'h31, 32'h31);
    wr_reg(8'h00, f | 32'h2000_0001);
    rd_reg(8'h00, 32'h31, 32'h01);
    dbg_hold <= 1'b0;
    wr_reg(8'h00, f);
    rd_reg(8'h00, 32'h31, 32'h30);
    n = nrd;
    repeat (10) @(posedge clk_sys);
    chk("paused beats", n, nrd);
    wr_reg(8'h00, f | 32'h1);
    wait_idle;
    chk("read beats", 32'h28, nrd);
    tpl <= '{32'h0, s, 1'b1, 1'b1, 1'b0, 16'h8};
    wr_reg(8'h08, 32'h100);
    start(32'h1, 32'h7);
    repeat (8) @(posedge clk_sys);
    err_in <= 3'h5;
    @(posedge clk_sys);
    err_in <= 3'h0;
    rd_reg(8'h00, 32'h47C, 32'h470);
    chk("urgent qos", {28'h0, u}, {28'h0, qos});
    req_lines[s] <= 1'b1;
    wait_idle;
    rd_reg(8'h00, 32'hE, 32'hE);
    rd_reg(8'h08, 32'h107, 32'h105);
    rd_reg(8'h08, 32'h107, 32'h100);
    rd_reg(8'h00, 32'h400, 32'h0);
    results;
  end
endmodule
`default_nettype wire
